//--- wdt_device.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - eight prescaler taps, phi/2 up to phi/4096
// - 8-bit counter increments on tick while running
// - overflow flag set on ff to 00
// - counter zero on reset or run cleared
// - overflow flag clears by read-1 then write-0
// - mode bit: 0 interval irq, 1 watchdog reset
// - run bit enables counting and interrupt requests
// - standby clears bits 7-5, keeps 2-0
// - control bits 4,3 read one, unwritable
// - software clears standby bit around run
// - init flag set on watchdog reset, cleared
// - init bits 7,6: pin reset clears them, internal reset keeps them
// - pin output driven low when enabled
// - init bits 5-0 read one, unwritable
// - word writes with password select register
// - write addresses ffa8 and ffaa
// - a5/00 word clears init flag after read-1
// - 5a word loads only output enable bit
// - byte reads at ffa8, ffa9, ffab
// - internal reset 518 states, pin 132
// - internal reset clears overflow, keeps init flag
// - interval irq follows overflow flag
// - counter write beats coincident increment
module wdt_device #(
    parameter int COUNT_W = 8
) (
    input  wire logic  mclk,
    input  wire logic  rst,
    wdt_bus_if.device  bus,
    input  wire logic  standby,
    output logic       chip_reset,
    output logic       interval_irq,
    output logic       pin_init_output,
    output logic       pin_init_output_oe_n
);

    if (COUNT_W != 8) begin : g_chk
        $error("wdt_device supports only an 8-bit counter");
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler tap mask: tick when the low bits are all ones
    function automatic logic [wdt_pkg::PRESCALE_W-1:0] tap_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    tap_mask = 12'h001;
            3'h1:    tap_mask = 12'h01f;
            3'h2:    tap_mask = 12'h03f;
            3'h3:    tap_mask = 12'h07f;
            3'h4:    tap_mask = 12'h0ff;
            3'h5:    tap_mask = 12'h1ff;
            3'h6:    tap_mask = 12'h7ff;
            default: tap_mask = 12'hfff;
        endcase
    endfunction

    logic [7:0]                       ctrl_q;
    logic [7:0]                       ctrl_d;
    logic [7:0]                       count_q;
    logic [7:0]                       count_d;
    logic                             iflag_q;
    logic                             iflag_d;
    logic                             oe_q;
    logic                             oe_d;
    logic                             oflow_armed_q;
    logic                             iflag_armed_q;
    logic [wdt_pkg::PRESCALE_W-1:0]   pre_q;
    logic [wdt_pkg::RESET_CNT_W-1:0]  int_cnt_q;
    logic [wdt_pkg::RESET_CNT_W-1:0]  int_cnt_d;
    logic [wdt_pkg::RESET_CNT_W-1:0]  pin_cnt_q;
    logic [wdt_pkg::RESET_CNT_W-1:0]  pin_cnt_d;
    logic                             chip_reset_q;
    logic                             irq_q;
    logic                             pin_oe_n_q;
    logic                             ack_q;
    logic [7:0]                       rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire        run       = ctrl_q[wdt_pkg::CTRL_RUN];
    wire        mode_wd   = ctrl_q[wdt_pkg::CTRL_MODE];
    wire        oflow     = ctrl_q[wdt_pkg::CTRL_OFLOW];
    wire [7:0]  hi        = bus.wdata[15:8];
    wire [7:0]  lo        = bus.wdata[7:0];
    wire        wr_word   = bus.wr & bus.word;
    wire        at_cw     = bus.addr == wdt_pkg::ADDR_CTRL_WR;
    wire        at_iw     = bus.addr == wdt_pkg::ADDR_INIT_WR;
    wire        wr_count  = wr_word & at_cw & (hi == wdt_pkg::PW_COUNT);
    wire        wr_ctrl   = wr_word & at_cw & (hi == wdt_pkg::PW_CTRL);
    wire        wr_iclr   = wr_word & at_iw & (hi == wdt_pkg::PW_CTRL) & (lo == 8'h00);
    wire        wr_ioe    = wr_word & at_iw & (hi == wdt_pkg::PW_COUNT);
    wire        rd_ctrl   = bus.rd & (bus.addr == wdt_pkg::ADDR_CTRL_RD);
    wire        rd_count  = bus.rd & (bus.addr == wdt_pkg::ADDR_COUNT_RD);
    wire        rd_init   = bus.rd & (bus.addr == wdt_pkg::ADDR_INIT_RD);

    ////////////////////////////////////////////////////////////////////////////
    // counter events
    wire        int_rst   = chip_reset_q;
    wire        tick      = (pre_q & tap_mask(ctrl_q[2:0])) == tap_mask(ctrl_q[2:0]);
    wire        inc       = tick & run & ~int_rst;
    wire        oflow_evt = inc & ~wr_count & (count_q == 8'hff);
    wire        wd_evt    = oflow_evt & mode_wd;
    wire        clr_oflow = wr_ctrl & ~lo[wdt_pkg::CTRL_OFLOW] & oflow_armed_q;
    wire        clr_iflag = wr_iclr & iflag_armed_q;
    wire [7:0]  ctrl_rd   = ctrl_q | wdt_pkg::CTRL_FIXED;
    wire [7:0]  init_rd   = {iflag_q, oe_q, 6'h00} | wdt_pkg::INIT_FIXED;

    ////////////////////////////////////////////////////////////////////////////
    // control register next value
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d[wdt_pkg::CTRL_MODE] = lo[wdt_pkg::CTRL_MODE];
            ctrl_d[wdt_pkg::CTRL_RUN]  = lo[wdt_pkg::CTRL_RUN];
            ctrl_d[2:0]                = lo[2:0];
        end
        if (clr_oflow) begin
            ctrl_d[wdt_pkg::CTRL_OFLOW] = 1'b0;
        end
        if (oflow_evt) begin
            ctrl_d[wdt_pkg::CTRL_OFLOW] = 1'b1;
        end
        if (standby) begin
            ctrl_d[7:5] = 3'h0;
        end
        if (int_rst) begin
            ctrl_d = wdt_pkg::CTRL_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter next value
    always_comb begin
        if (int_rst || !run) begin
            count_d = wdt_pkg::COUNT_RESET;
        end else if (wr_count) begin
            count_d = lo;
        end else if (inc) begin
            count_d = count_q + 8'h01;
        end else begin
            count_d = count_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // init status next value; internal reset leaves these alone
    always_comb begin
        iflag_d = iflag_q;
        oe_d    = oe_q;
        if (clr_iflag) begin
            iflag_d = 1'b0;
        end
        if (wd_evt) begin
            iflag_d = 1'b1;
        end
        if (wr_ioe) begin
            oe_d = lo[wdt_pkg::INIT_OE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset pulse counters
    always_comb begin
        int_cnt_d = int_cnt_q;
        pin_cnt_d = pin_cnt_q;
        if (int_cnt_q != '0) begin
            int_cnt_d = int_cnt_q - 10'd1;
        end
        if (pin_cnt_q != '0) begin
            pin_cnt_d = pin_cnt_q - 10'd1;
        end
        if (wd_evt) begin
            int_cnt_d = wdt_pkg::RESET_CNT_W'(wdt_pkg::INT_RESET_CYCLES);
            if (oe_q) begin
                pin_cnt_d = wdt_pkg::RESET_CNT_W'(wdt_pkg::PIN_RESET_CYCLES);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers under pin reset; rst is the external reset pin
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q  <= wdt_pkg::CTRL_RESET;
            count_q <= wdt_pkg::COUNT_RESET;
            pre_q   <= '0;
        end else begin
            ctrl_q  <= ctrl_d;
            count_q <= count_d;
            pre_q   <= int_rst ? '0 : pre_q + 12'h001;
        end
    end

    // init status bits, cleared by the pin reset, kept by the internal reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            iflag_q <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            iflag_q <= iflag_d;
            oe_q   <= oe_d;
        end
    end

    // read-as-one tracking for the two flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            oflow_armed_q <= 1'b0;
            iflag_armed_q <= 1'b0;
        end else begin
            oflow_armed_q <= ctrl_d[wdt_pkg::CTRL_OFLOW] & (oflow_armed_q | (rd_ctrl & oflow));
            iflag_armed_q <= iflag_d & (iflag_armed_q | (rd_init & iflag_q));
        end
    end

    // reset pulse timing and outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            int_cnt_q    <= '0;
            pin_cnt_q    <= '0;
            chip_reset_q <= 1'b0;
            pin_oe_n_q   <= 1'b1;
            irq_q        <= 1'b0;
        end else begin
            int_cnt_q    <= int_cnt_d;
            pin_cnt_q    <= pin_cnt_d;
            chip_reset_q <= int_cnt_d != '0;
            pin_oe_n_q   <= pin_cnt_d == '0;
            irq_q        <= ctrl_d[wdt_pkg::CTRL_OFLOW] & ~ctrl_d[wdt_pkg::CTRL_MODE]
                            & ctrl_d[wdt_pkg::CTRL_RUN];
        end
    end

    // bus answer, one cycle after the strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ack_q   <= bus.rd | bus.wr;
            rdata_q <= rd_ctrl  ? ctrl_rd :
                       rd_count ? count_q :
                       rd_init  ? init_rd : 8'h00;
        end
    end

    assign bus.ack              = ack_q;
    assign bus.rdata            = rdata_q;
    assign chip_reset           = chip_reset_q;
    assign interval_irq         = irq_q;
    assign pin_init_output      = 1'b0;
    assign pin_init_output_oe_n = pin_oe_n_q;

endmodule

//--- wdt_pkg.sv
package wdt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // peripheral bus addresses and passwords
    localparam logic [15:0] ADDR_CTRL_WR  = 16'hffa8;
    localparam logic [15:0] ADDR_INIT_WR  = 16'hffaa;
    localparam logic [15:0] ADDR_CTRL_RD  = 16'hffa8;
    localparam logic [15:0] ADDR_COUNT_RD = 16'hffa9;
    localparam logic [15:0] ADDR_INIT_RD  = 16'hffab;
    localparam logic [7:0]  PW_COUNT      = 8'h5a;
    localparam logic [7:0]  PW_CTRL       = 8'ha5;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and fixed bits
    localparam logic [7:0] CTRL_RESET  = 8'h18;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] INIT_RESET  = 8'h3f;
    localparam logic [7:0] CTRL_FIXED  = 8'h18;
    localparam logic [7:0] INIT_FIXED  = 8'h3f;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_OFLOW = 7;
    localparam int CTRL_MODE = 6;
    localparam int CTRL_RUN  = 5;
    localparam int INIT_FLAG = 7;
    localparam int INIT_OE   = 6;

    ////////////////////////////////////////////////////////////////////////////
    // timing: one state is one mclk period
    localparam int STATES_PER_CYCLE  = 1;
    localparam int INT_RESET_STATES  = 518;
    localparam int PIN_RESET_STATES  = 132;
    localparam int INT_RESET_CYCLES  = INT_RESET_STATES / STATES_PER_CYCLE;
    localparam int PIN_RESET_CYCLES  = PIN_RESET_STATES / STATES_PER_CYCLE;
    localparam int RESET_CNT_W       = 10;
    localparam int PRESCALE_W        = 12;

    ////////////////////////////////////////////////////////////////////////////
    // host controller apb map
    localparam logic [7:0] HOST_ADDR   = 8'h00;
    localparam logic [7:0] HOST_WDATA  = 8'h04;
    localparam logic [7:0] HOST_CMD    = 8'h08;
    localparam logic [7:0] HOST_STATUS = 8'h0c;
    localparam int CMD_GO    = 0;
    localparam int CMD_READ  = 1;
    localparam int CMD_WORD  = 2;
    localparam int STAT_BUSY = 0;
    localparam int STAT_RD_LSB = 8;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_REQ  = 2'b01,
        HOST_WAIT = 2'b10
    } host_state_t;

endpackage

//--- wdt_bus_if.sv
`timescale 1ns/1ps
interface wdt_bus_if;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        word;
    logic        rd;
    logic [7:0]  rdata;
    logic        ack;

    modport device (input addr, input wdata, input wr, input word, input rd, output rdata, output ack);
    modport host   (output addr, output wdata, output wr, output word, output rd, input rdata, input ack);
endinterface

//--- wdt_host.sv
`timescale 1ns/1ps
module wdt_host (
    input  wire logic         mclk,
    input  wire logic         rst,
    wdt_bus_if.host           bus,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr
);

    wdt_pkg::host_state_t  state_q;
    wdt_pkg::host_state_t  state_d;
    logic [15:0]           addr_q;
    logic [15:0]           wdata_q;
    logic                  is_read_q;
    logic                  is_word_q;
    logic [7:0]            rdata_q;
    logic                  pready_q;
    logic [31:0]           prdata_q;
    logic                  wr_q;
    logic                  rd_q;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; one wait state so read data comes from a flop
    wire        access  = psel & penable;
    wire        commit  = access & pready_q & pwrite;
    wire        busy    = state_q != wdt_pkg::HOST_IDLE;
    wire        go      = commit & (paddr == wdt_pkg::HOST_CMD) & pwdata[wdt_pkg::CMD_GO] & ~busy;
    wire [31:0] rd_mux  = (paddr == wdt_pkg::HOST_ADDR)   ? {16'h0000, addr_q} :
                          (paddr == wdt_pkg::HOST_WDATA)  ? {16'h0000, wdata_q} :
                          (paddr == wdt_pkg::HOST_CMD)    ? {29'h0, is_word_q, is_read_q, 1'b0} :
                          (paddr == wdt_pkg::HOST_STATUS) ? {16'h0000, rdata_q, 7'h00, busy} : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // bus sequencer: strobe one cycle, then wait for the answer
    always_comb begin
        case (state_q)
            wdt_pkg::HOST_IDLE: state_d = go ? wdt_pkg::HOST_REQ : wdt_pkg::HOST_IDLE;
            wdt_pkg::HOST_REQ:  state_d = wdt_pkg::HOST_WAIT;
            wdt_pkg::HOST_WAIT: state_d = bus.ack ? wdt_pkg::HOST_IDLE : wdt_pkg::HOST_WAIT;
            default:            state_d = wdt_pkg::HOST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q   <= wdt_pkg::HOST_IDLE;
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            rdata_q   <= 8'h00;
        end else begin
            state_q   <= state_d;
            wr_q      <= go & ~pwdata[wdt_pkg::CMD_READ];
            rd_q      <= go & pwdata[wdt_pkg::CMD_READ];
            if (state_q == wdt_pkg::HOST_WAIT && bus.ack && is_read_q) begin
                rdata_q <= bus.rdata;
            end
        end
    end

    // command registers, frozen while a transfer runs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_q    <= 16'h0000;
            wdata_q   <= 16'h0000;
            is_read_q <= 1'b0;
            is_word_q <= 1'b0;
        end else if (commit && !busy) begin
            if (paddr == wdt_pkg::HOST_ADDR) begin
                addr_q <= pwdata[15:0];
            end
            if (paddr == wdt_pkg::HOST_WDATA) begin
                wdata_q <= pwdata[15:0];
            end
            if (paddr == wdt_pkg::HOST_CMD) begin
                is_read_q <= pwdata[wdt_pkg::CMD_READ];
                is_word_q <= pwdata[wdt_pkg::CMD_WORD];
            end
        end
    end

    // apb answer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= access & ~pready_q;
            prdata_q <= (access & ~pready_q & ~pwrite) ? rd_mux : prdata_q;
        end
    end

    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr    = wr_q;
    assign bus.rd    = rd_q;
    assign bus.word  = is_word_q;
    assign pready    = pready_q;
    assign prdata    = prdata_q;
    assign pslverr   = 1'b0;

endmodule

//--- wdt_chk.sv
`timescale 1ns/1ps
module wdt_chk (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [15:0] addr,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [7:0]  rdata,
    input  wire logic        ack,
    input  wire logic        chip_reset,
    input  wire logic        interval_irq,
    input  wire logic        pin_init_output_oe_n
);
    logic [9:0] int_len_q;
    logic [9:0] pin_len_q;

    ////////////////////////////////////////////////////////////////////////////
    // cycles spent in internal reset and in pin drive
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            int_len_q <= 10'h000;
            pin_len_q <= 10'h000;
        end else begin
            int_len_q <= chip_reset ? int_len_q + 10'h001 : 10'h000;
            pin_len_q <= !pin_init_output_oe_n ? pin_len_q + 10'h001 : 10'h000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read transfers seen on the bus
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_ctrl_read; rd && addr == wdt_pkg::ADDR_CTRL_RD ##1 ack; endsequence
    sequence s_init_read; rd && addr == wdt_pkg::ADDR_INIT_RD ##1 ack; endsequence
    sequence s_flag_read; interval_irq && rd && addr == wdt_pkg::ADDR_CTRL_RD ##1 ack; endsequence

    ////////////////////////////////////////////////////////////////////////////
    // bus answers, fixed bits, reset pulse lengths
    a_ack_follows_strobe: assert property ((wr || rd) |=> ack)
        else $error("strobe without ack");
    a_ack_has_cause: assert property (ack |-> $past(wr) || $past(rd))
        else $error("ack without strobe");
    a_ctrl_fixed_ones: assert property (s_ctrl_read |-> rdata[4:3] == 2'b11)
        else $error("control reserved bits not one");
    a_init_fixed_ones: assert property (s_init_read |-> rdata[5:0] == 6'h3f)
        else $error("init reserved bits not one");
    a_irq_shows_flag: assert property (s_flag_read |-> rdata[7])
        else $error("interval request without overflow flag");
    a_int_reset_len: assert property ($fell(chip_reset) |-> int_len_q == 10'(wdt_pkg::INT_RESET_CYCLES))
        else $error("internal reset length wrong");
    a_int_reset_cap: assert property (chip_reset |-> int_len_q < 10'(wdt_pkg::INT_RESET_CYCLES))
        else $error("internal reset too long");
    a_pin_reset_len: assert property ($rose(pin_init_output_oe_n) |-> pin_len_q == 10'(wdt_pkg::PIN_RESET_CYCLES))
        else $error("pin drive length wrong");
    a_pin_in_reset: assert property (!pin_init_output_oe_n |-> chip_reset)
        else $error("pin driven outside internal reset");
    a_pin_starts_together: assert property ($fell(pin_init_output_oe_n) |-> $rose(chip_reset))
        else $error("pin drive not aligned to reset");
    a_irq_quiet_reset: assert property (chip_reset |-> !interval_irq)
        else $error("interval request during watchdog reset");
endmodule

//--- watchdog_interval_timer_tb.sv
`timescale 1ns/1ps
module watchdog_interval_timer_tb;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        standby = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, chip_reset, interval_irq, pin_init_output, pin_init_output_oe_n;
    logic        irq_d = 1'b0;
    int          failures = 0;
    int          checks_done = 0;
    int          rises = 0;
    int          divs [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
    real         rise_t = 0.0;
    localparam logic [31:0] WR_WORD = (32'h1 << wdt_pkg::CMD_GO) | (32'h1 << wdt_pkg::CMD_WORD);
    localparam logic [31:0] WR_BYTE = 32'h1 << wdt_pkg::CMD_GO;
    localparam logic [31:0] RD_BYTE = (32'h1 << wdt_pkg::CMD_GO) | (32'h1 << wdt_pkg::CMD_READ);
    localparam logic [15:0] A_CTRL = wdt_pkg::ADDR_CTRL_WR;
    localparam logic [15:0] A_INIT = wdt_pkg::ADDR_INIT_WR;

    wdt_bus_if bus ();
    wdt_device wdt_device_inst (.mclk(mclk), .rst(rst), .bus(bus.device), .standby(standby),
        .chip_reset(chip_reset), .interval_irq(interval_irq), .pin_init_output(pin_init_output),
        .pin_init_output_oe_n(pin_init_output_oe_n));
    wdt_host wdt_host_inst (.mclk(mclk), .rst(rst), .bus(bus.host), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    wdt_chk wdt_chk_inst (.mclk(mclk), .rst(rst), .addr(bus.addr), .wr(bus.wr), .rd(bus.rd),
        .rdata(bus.rdata), .ack(bus.ack), .chip_reset(chip_reset), .interval_irq(interval_irq),
        .pin_init_output_oe_n(pin_init_output_oe_n));

    ////////////////////////////////////////////////////////////////////////////
    // clock, and a recorder of interval request rising edges
    always #20 mclk = ~mclk;
    always @(negedge mclk) begin
        if (interval_irq === 1'b1 && irq_d !== 1'b1) begin
            rises = rises + 1;
            rise_t = $realtime;
        end
        irq_d = interval_irq;
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // one device access through the host, waits until it is no longer busy
    task automatic dev(input logic [15:0] a, input logic [15:0] w, input logic [31:0] cmd, output logic [7:0] b);
        logic [31:0] r;
        apb(1'b1, wdt_pkg::HOST_ADDR, {16'h0, a}, r);
        apb(1'b1, wdt_pkg::HOST_WDATA, {16'h0, w}, r);
        apb(1'b1, wdt_pkg::HOST_CMD, cmd, r);
        r = 32'h1;
        while (r[wdt_pkg::STAT_BUSY] !== 1'b0) apb(1'b0, wdt_pkg::HOST_STATUS, 32'h0, r);
        b = r[wdt_pkg::STAT_RD_LSB +: 8];
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] b;
        dev(a, 16'h0, RD_BYTE, b);
        chk(b, exp, "register read");
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] pw, input logic [7:0] d);
        logic [7:0] b;
        dev(a, {pw, d}, WR_WORD, b);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard
    initial begin
        repeat (90000) @(posedge mclk);
        failures++;
        $display("wrong value at %0t ns: run did not finish", $time);
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        int n;
        int d;
        real t0;
        logic [7:0] b;
        logic en;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd_chk(wdt_pkg::ADDR_CTRL_RD, 8'h18);
        rd_chk(wdt_pkg::ADDR_COUNT_RD, 8'h00);
        rd_chk(wdt_pkg::ADDR_INIT_RD, 8'h3f);
        rd_chk(16'hffaa, 8'h00);
        chk({7'h0, pslverr}, 8'h00, "bus error");
        $display("test reset_values done");
        wr(A_CTRL, wdt_pkg::PW_CTRL, 8'h47); rd_chk(A_CTRL, 8'h5f);
        dev(A_CTRL, {wdt_pkg::PW_CTRL, 8'h00}, WR_BYTE, b); rd_chk(A_CTRL, 8'h5f);
        wr(A_CTRL, 8'h33, 8'h00); rd_chk(A_CTRL, 8'h5f);
        wr(A_INIT, 8'h33, 8'h40); rd_chk(wdt_pkg::ADDR_INIT_RD, 8'h3f);
        standby <= 1'b1;
        @(posedge mclk);
        standby <= 1'b0;
        rd_chk(A_CTRL, 8'h1f);
        $display("test write_protection done");
        for (int k = 0; k < 8; k++) begin
            wr(A_CTRL, wdt_pkg::PW_CTRL, 8'h20 | 8'(k));
            n = rises;
            wr(A_CTRL, wdt_pkg::PW_COUNT, 8'hff);
            while (rises == n) @(posedge mclk);
            t0 = rise_t;
            rd_chk(A_CTRL, 8'hb8 | 8'(k));
            n = rises;
            wr(A_CTRL, wdt_pkg::PW_CTRL, 8'h20 | 8'(k));
            wr(A_CTRL, wdt_pkg::PW_COUNT, 8'hfc);
            while (rises == n) @(posedge mclk);
            d = int'((rise_t - t0) / 40.0);
            chk({7'h0, d % divs[k] == 0 && d >= 4 * divs[k] && d <= 5 * divs[k] + 300}, 8'h01, "tick spacing");
            rd_chk(A_CTRL, 8'hb8 | 8'(k));
            wr(A_CTRL, wdt_pkg::PW_CTRL, 8'(k));
            rd_chk(wdt_pkg::ADDR_COUNT_RD, 8'h00);
            rd_chk(A_CTRL, 8'h18 | 8'(k));
        end
        $display("test prescaler done");
        for (int i = 0; i < 2; i++) begin
            en = (i == 0);
            wr(A_INIT, wdt_pkg::PW_COUNT, {1'b0, en, 6'h00}); rd_chk(wdt_pkg::ADDR_INIT_RD, {1'b0, en, 6'h3f});
            wr(A_CTRL, wdt_pkg::PW_CTRL, 8'h60);
            wr(A_CTRL, wdt_pkg::PW_COUNT, 8'hff);
            do @(negedge mclk); while (chip_reset !== 1'b1);
            chk({7'h0, pin_init_output_oe_n}, {7'h0, ~en}, "pin drive");
            chk({7'h0, pin_init_output}, 8'h00, "pin level");
            do @(negedge mclk); while (chip_reset !== 1'b0);
            @(posedge mclk);
            rd_chk(wdt_pkg::ADDR_INIT_RD, {1'b1, en, 6'h3f});
            rd_chk(A_CTRL, 8'h18);
            wr(A_INIT, wdt_pkg::PW_CTRL, 8'h00); rd_chk(wdt_pkg::ADDR_INIT_RD, {1'b0, en, 6'h3f});
        end
        $display("test watchdog_reset done");
        wr(A_INIT, wdt_pkg::PW_COUNT, 8'h40);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd_chk(wdt_pkg::ADDR_INIT_RD, 8'h3f);
        $display("test pin_reset done");
        give_verdict();
    end
endmodule
